// ===== rtl/spe_top.sv
// Operation
// - Erase given row count from base, max 128
// - Address high byte with count, low word next
// - Erased bytes read back as 0xFF
// - Row erase success answers 0x1800, 0x0002
// - Row erase refuses a base at page 0xF8 or above; later rows unchecked
// - First response word carries query/error byte
// - Queries always answer with pass status
// - Blank query gives 0xF0 blank, 0x0F not
// - Version byte is major then minor nibble
// - Error 0 ok, 1 verify, 2 other
// - Length counts header; most responses two words
// - Data read response is N plus two
// - Code read length follows packed formula
// - Eight idle cycles, then sixteen shift cycles
// - Data pin driven until next rising edge
// - Reserved opcode answers negative acknowledge
module spe_top (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic PROG_CLOCK_PIN,
	input wire logic PROG_DATA_PIN_I,
	output logic PROG_DATA_PIN_O,
	output logic PROG_DATA_PIN_OE,
	input wire logic [15:0] VISIBLE_RESULT_REG,
	output logic CPU_IDLE,
	output logic [23:0] INSTR_WORD,
	output logic INSTR_VALID,
	input wire logic [15:0] CMD_WORD,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	output logic [15:0] ARG_WORD,
	output logic ARG_VALID,
	output logic OP_START,
	output logic [3:0] OP_CODE,
	input wire logic OP_DONE,
	input wire logic OP_VERIFY_FAIL,
	input wire logic OP_FAIL,
	input wire logic MEM_BLANK,
	output logic ERASE_ROW_REQ,
	output logic [23:0] ERASE_ROW_ADDR,
	output logic [7:0] ERASE_FILL,
	input wire logic ERASE_ROW_DONE,
	input wire logic [15:0] RD_WORD,
	input wire logic RD_VALID,
	output logic RD_READY,
	output logic [15:0] RSP_WORD,
	output logic RSP_VALID,
	input wire logic RSP_READY
);
	// Last-count values for the serial bit counter
	localparam logic [4:0] CODE_LAST = 5'(spe_pkg::CODE_BITS - 1);
	localparam logic [4:0] INSTR_LAST = 5'(spe_pkg::INSTR_BITS - 1);
	localparam logic [4:0] PROC_LAST = 5'(spe_pkg::PROCESS_CYCLES - 1);
	localparam logic [4:0] SHIFT_LAST = 5'(spe_pkg::SHIFT_OUT_BITS - 1);

	typedef enum logic [1:0] {
		SR_CODE = 2'b00,
		SR_PROC = 2'b01,
		SR_SHIFT = 2'b11,
		SR_PAYLOAD = 2'b10
	} spe_ser_t;

	typedef enum logic [2:0] {
		EX_IDLE = 3'b000,
		EX_COLLECT = 3'b001,
		EX_DECODE = 3'b011,
		EX_ERASE = 3'b010,
		EX_WAIT = 3'b110,
		EX_RSP0 = 3'b111,
		EX_RSP1 = 3'b101,
		EX_RDFWD = 3'b100
	} spe_ex_t;

	// Response length in words for a given opcode and read count
	function automatic logic [15:0] rsp_len(input logic [3:0] op,
			input logic [7:0] n);
		logic [15:0] nn;
		nn = {8'h00, n};
		if (op == spe_pkg::OP_DATA_WORD_READ) begin
			rsp_len = nn + spe_pkg::HDR_LEN;
		end else if (op == spe_pkg::OP_CODE_WORD_READ && n[0]) begin
			rsp_len = 16'(3 * ((nn + 16'h0001) >> 1)) + spe_pkg::HDR_LEN;
		end else if (op == spe_pkg::OP_CODE_WORD_READ) begin
			rsp_len = 16'(3 * (nn >> 1)) + spe_pkg::HDR_LEN;
		end else begin
			rsp_len = spe_pkg::HDR_LEN;
		end
	endfunction

	// Pin synchronisers and edge history
	logic pc_s1_q, pc_s2_q, pc_s3_q; // Clock pin stages
	logic pd_s1_q, pd_s2_q; // Data pin stages
	logic pc_rise; // Rising edge of programming clock

	// Serial engine state
	spe_ser_t ser_q, ser_d; // Serial phase
	logic [4:0] cnt_q, cnt_d; // Bit or cycle count
	logic [3:0] code_q, code_d; // Control code being shifted in
	logic [3:0] code_next; // Code with current bit added
	logic [23:0] sh_q, sh_d; // Instruction payload shifter
	logic [23:0] sh_next; // Payload with current bit added
	logic [15:0] result_q, result_d; // Result register being shifted out
	logic hold_q, hold_d; // Core held after shift-out until next code
	logic oe_q, oe_d; // Data pin drive enable
	logic dout_q, dout_d; // Data pin level
	logic [23:0] instr_q, instr_d; // Completed instruction
	logic ivld_q, ivld_d; // Instruction strobe

	// Executive state
	spe_ex_t ex_q, ex_d; // Command phase
	logic [3:0] op_q, op_d; // Opcode in progress
	logic [7:0] left_q, left_d; // Command words still expected
	logic [1:0] idx_q, idx_d; // Index of next command word
	logic [15:0] w1_q, w1_d; // Second command word
	logic [15:0] w2_q, w2_d; // Third command word
	logic [7:0] rows_q, rows_d; // Rows still to erase
	logic [23:0] addr_q, addr_d; // Row being erased
	logic ereq_q, ereq_d; // Row erase strobe
	logic ostart_q, ostart_d; // External operation strobe
	logic [15:0] arg_q, arg_d; // Forwarded argument word
	logic avld_q, avld_d; // Argument strobe
	spe_pkg::spe_rsp_hdr_t hdr_q, hdr_d; // First response word
	logic [15:0] len_q, len_d; // Response length
	logic [15:0] rem_q, rem_d; // Read words still to forward

	// Decoded command fields and buffer handshake
	spe_pkg::spe_cmd_hdr_t cmd_hdr; // First word view
	spe_pkg::spe_erase_w1_t erase_w1; // Row erase second word view
	logic [23:0] erase_base; // Joined base address
	logic erase_bad; // Row erase arguments refused
	logic prog_op; // Opcode has a verify step
	logic cmd_fire; // Command word taken
	logic fifo_in_valid, fifo_in_ready, fifo_empty;
	logic [15:0] fifo_in_data;

	assign pc_rise = pc_s2_q && !pc_s3_q;
	assign code_next = {pd_s2_q, code_q[3:1]};
	assign sh_next = {pd_s2_q, sh_q[23:1]};

	assign cmd_hdr = CMD_WORD;
	assign erase_w1 = w1_q;
	assign erase_base = {erase_w1.addr_high, w2_q};
	assign erase_bad = (erase_w1.num_rows == 8'h00)
		|| (erase_w1.num_rows > spe_pkg::MAX_ROWS)
		|| ((erase_base & spe_pkg::ROW_ALIGN_MASK) != 24'h000000)
		|| (erase_w1.addr_high >= spe_pkg::PROTECT_PAGE);
	assign prog_op = (op_q == spe_pkg::OP_DATA_ROW_PROGRAM)
		|| (op_q == spe_pkg::OP_CODE_ROW_PROGRAM)
		|| (op_q == spe_pkg::OP_CONFIG_PROGRAM);
	assign CMD_READY = (ex_q == EX_IDLE && fifo_empty)
		|| ex_q == EX_COLLECT;
	assign cmd_fire = CMD_VALID && CMD_READY;
	assign RD_READY = (ex_q == EX_RDFWD) && fifo_in_ready;
	assign fifo_in_valid = (ex_q == EX_RSP0) || (ex_q == EX_RSP1)
		|| (ex_q == EX_RDFWD && RD_VALID);
	assign fifo_in_data = (ex_q == EX_RSP0) ? hdr_q
		: (ex_q == EX_RSP1) ? len_q : RD_WORD;

	assign PROG_DATA_PIN_O = dout_q;
	assign PROG_DATA_PIN_OE = oe_q;
	assign CPU_IDLE = (ser_q == SR_PROC) || (ser_q == SR_SHIFT)
		|| hold_q;
	assign INSTR_WORD = instr_q;
	assign INSTR_VALID = ivld_q;
	assign ARG_WORD = arg_q;
	assign ARG_VALID = avld_q;
	assign OP_START = ostart_q;
	assign OP_CODE = op_q;
	assign ERASE_ROW_REQ = ereq_q;
	assign ERASE_ROW_ADDR = addr_q;
	assign ERASE_FILL = spe_pkg::ERASE_FILL_BYTE;

	// Two-stage pin synchronisers, third stage for edge finding
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			{pc_s1_q, pc_s2_q, pc_s3_q} <= 3'h0;
			{pd_s1_q, pd_s2_q} <= 2'h0;
		end else begin
			{pc_s1_q, pc_s2_q, pc_s3_q} <= {PROG_CLOCK_PIN, pc_s1_q, pc_s2_q};
			{pd_s1_q, pd_s2_q} <= {PROG_DATA_PIN_I, pd_s1_q};
		end
	end

	// Serial engine next state, advanced on programming clock rises
	always_comb begin
		ser_d = ser_q;
		cnt_d = cnt_q;
		code_d = code_q;
		sh_d = sh_q;
		result_d = result_q;
		hold_d = hold_q;
		oe_d = oe_q;
		dout_d = dout_q;
		instr_d = instr_q;
		ivld_d = 1'b0;
		if (pc_rise) begin
			cnt_d = cnt_q + 5'h01;
			case (ser_q)
				SR_CODE: begin
					code_d = code_next;
					if (cnt_q == CODE_LAST) begin
						cnt_d = 5'h00;
						// A complete code ends the hold left by the last shift-out
						hold_d = 1'b0;
						// Register shift-out holds the core; all else executes
						ser_d = (code_next == spe_pkg::CODE_SHIFT_OUT)
							? SR_PROC : SR_PAYLOAD;
					end
				end
				SR_PAYLOAD: begin
					sh_d = sh_next;
					if (cnt_q == INSTR_LAST) begin
						cnt_d = 5'h00;
						instr_d = sh_next;
						ivld_d = 1'b1;
						ser_d = SR_CODE;
					end
				end
				SR_PROC: begin
					if (cnt_q == PROC_LAST) begin
						cnt_d = 5'h00;
						result_d = VISIBLE_RESULT_REG;
						dout_d = VISIBLE_RESULT_REG[0];
						oe_d = 1'b1;
						ser_d = SR_SHIFT;
					end
				end
				SR_SHIFT: begin
					result_d = {1'b0, result_q[15:1]};
					dout_d = result_q[1];
					if (cnt_q == SHIFT_LAST) begin
						cnt_d = 5'h00;
						// Core stays idle until the next code arrives
						hold_d = 1'b1;
						oe_d = 1'b0;
						dout_d = 1'b0;
						ser_d = SR_CODE;
					end
				end
				default: begin
					ser_d = SR_CODE;
					cnt_d = 5'h00;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	// Serial engine registers
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ser_q <= SR_CODE;
			{cnt_q, code_q, sh_q, result_q} <= '0;
			{oe_q, dout_q, instr_q, ivld_q, hold_q} <= '0;
		end else begin
			ser_q <= ser_d;
			{cnt_q, code_q, sh_q, result_q} <=
				{cnt_d, code_d, sh_d, result_d};
			{oe_q, dout_q, instr_q, ivld_q, hold_q} <=
				{oe_d, dout_d, instr_d, ivld_d, hold_d};
		end
	end

	// Executive command sequencer
	always_comb begin
		ex_d = ex_q;
		op_d = op_q;
		left_d = left_q;
		idx_d = idx_q;
		w1_d = w1_q;
		w2_d = w2_q;
		rows_d = rows_q;
		addr_d = addr_q;
		ereq_d = 1'b0;
		ostart_d = 1'b0;
		arg_d = arg_q;
		avld_d = 1'b0;
		hdr_d = hdr_q;
		len_d = len_q;
		rem_d = rem_q;
		case (ex_q)
			EX_IDLE: begin
				if (cmd_fire) begin
					op_d = cmd_hdr.opcode;
					idx_d = 2'h1;
					left_d = (cmd_hdr.length > 8'h01)
						? cmd_hdr.length - 8'h01 : 8'h00;
					ex_d = (cmd_hdr.length > 8'h01) ? EX_COLLECT : EX_DECODE;
				end
			end
			EX_COLLECT: begin
				if (cmd_fire) begin
					// Every argument word is also passed to the executor
					arg_d = CMD_WORD;
					avld_d = 1'b1;
					if (idx_q == 2'h1) begin
						w1_d = CMD_WORD;
					end
					if (idx_q == 2'h2) begin
						w2_d = CMD_WORD;
					end
					if (idx_q != 2'h3) begin
						idx_d = idx_q + 2'h1;
					end
					left_d = left_q - 8'h01;
					if (left_q == 8'h01) begin
						ex_d = EX_DECODE;
					end
				end
			end
			EX_DECODE: begin
				hdr_d = '{spe_pkg::RSP_PASS, op_q, spe_pkg::QE_OK};
				len_d = rsp_len(op_q, w1_q[7:0]);
				ex_d = EX_RSP0;
				if (op_q == spe_pkg::OP_DATA_ROW_ERASE) begin
					if (erase_bad) begin
						hdr_d.status = spe_pkg::RSP_FAIL;
						hdr_d.query_error_field = spe_pkg::QE_OTHER;
					end else begin
						rows_d = erase_w1.num_rows;
						addr_d = erase_base;
						ereq_d = 1'b1;
						ex_d = EX_ERASE;
					end
				end else if (op_q == spe_pkg::OP_BLANK_QUERY) begin
					hdr_d.query_error_field = MEM_BLANK
						? spe_pkg::QE_BLANK : spe_pkg::QE_NOT_BLANK;
				end else if (op_q == spe_pkg::OP_VERSION_QUERY) begin
					hdr_d.query_error_field = {spe_pkg::VERSION_MAJOR,
						spe_pkg::VERSION_MINOR};
				end else if (op_q == spe_pkg::OP_RESERVED
						|| op_q > spe_pkg::OP_VERSION_QUERY) begin
					hdr_d.status = spe_pkg::RSP_NACK;
				end else if (op_q == spe_pkg::OP_DATA_WORD_READ
						|| op_q == spe_pkg::OP_CODE_WORD_READ) begin
					ostart_d = 1'b1;
				end else begin
					ostart_d = 1'b1;
					ex_d = EX_WAIT;
				end
			end
			EX_ERASE: begin
				if (ERASE_ROW_DONE) begin
					rows_d = rows_q - 8'h01;
					addr_d = addr_q + spe_pkg::ROW_STEP;
					if (rows_q == 8'h01) begin
						ex_d = EX_RSP0;
					end else begin
						ereq_d = 1'b1;
					end
				end
			end
			EX_WAIT: begin
				if (OP_DONE) begin
					if (OP_VERIFY_FAIL && prog_op) begin
						hdr_d.status = spe_pkg::RSP_FAIL;
						hdr_d.query_error_field = spe_pkg::QE_VERIFY_FAIL;
					end else if (OP_FAIL || OP_VERIFY_FAIL) begin
						hdr_d.status = spe_pkg::RSP_FAIL;
						hdr_d.query_error_field = spe_pkg::QE_OTHER;
					end
					ex_d = EX_RSP0;
				end
			end
			EX_RSP0: begin
				if (fifo_in_ready) begin
					ex_d = EX_RSP1;
				end
			end
			EX_RSP1: begin
				if (fifo_in_ready) begin
					rem_d = len_q - spe_pkg::HDR_LEN;
					ex_d = (len_q > spe_pkg::HDR_LEN) ? EX_RDFWD : EX_IDLE;
				end
			end
			EX_RDFWD: begin
				if (RD_VALID && fifo_in_ready) begin
					rem_d = rem_q - 16'h0001;
					if (rem_q == 16'h0001) begin
						ex_d = EX_IDLE;
					end
				end
			end
			default: begin
				ex_d = EX_IDLE;
			end
		endcase
	end

	// Executive registers
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ex_q <= EX_IDLE;
			{op_q, left_q, idx_q, w1_q, w2_q} <= '0;
			{rows_q, addr_q, ereq_q, ostart_q, arg_q, avld_q} <= '0;
			{hdr_q, len_q, rem_q} <= '0;
		end else begin
			ex_q <= ex_d;
			{op_q, left_q, idx_q, w1_q, w2_q} <=
				{op_d, left_d, idx_d, w1_d, w2_d};
			{rows_q, addr_q, ereq_q, ostart_q, arg_q, avld_q} <=
				{rows_d, addr_d, ereq_d, ostart_d, arg_d, avld_d};
			{hdr_q, len_q, rem_q} <= {hdr_d, len_d, rem_d};
		end
	end

	// Response buffer toward the programmer link
	spe_fifo #(
		.W(spe_pkg::WORD_W),
		.D(spe_pkg::FIFO_DEPTH)
	) u_rsp_fifo (
		.clk(CLK),
		.arst_n(ARST_N),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(RSP_VALID),
		.out_ready(RSP_READY),
		.out_data(RSP_WORD),
		.empty(fifo_empty)
	);

endmodule

// ===== common/spe_pkg.sv
package spe_pkg;

	// Serial control codes, shifted in least significant bit first
	localparam logic [3:0] CODE_EXEC = 4'h0;
	localparam logic [3:0] CODE_SHIFT_OUT = 4'h1;

	// Serial timing, in programming-clock cycles
	localparam int CODE_BITS = 4;
	localparam int INSTR_BITS = 24;
	localparam int PROCESS_CYCLES = 8;
	localparam int SHIFT_OUT_BITS = 16;

	// Executive opcodes
	localparam logic [3:0] OP_SANITY = 4'h0;
	localparam logic [3:0] OP_DATA_WORD_READ = 4'h1;
	localparam logic [3:0] OP_CODE_WORD_READ = 4'h2;
	localparam logic [3:0] OP_RESERVED = 4'h3;
	localparam logic [3:0] OP_DATA_ROW_PROGRAM = 4'h4;
	localparam logic [3:0] OP_CODE_ROW_PROGRAM = 4'h5;
	localparam logic [3:0] OP_CONFIG_PROGRAM = 4'h6;
	localparam logic [3:0] OP_BULK_ERASE_CMD = 4'h7;
	localparam logic [3:0] OP_DATA_ROW_ERASE = 4'h8;
	localparam logic [3:0] OP_CODE_ROW_ERASE = 4'h9;
	localparam logic [3:0] OP_BLANK_QUERY = 4'hA;
	localparam logic [3:0] OP_VERSION_QUERY = 4'hB;

	// Response status codes
	localparam logic [3:0] RSP_PASS = 4'h1;
	localparam logic [3:0] RSP_FAIL = 4'h2;
	localparam logic [3:0] RSP_NACK = 4'h3;

	// Query and error field values
	localparam logic [7:0] QE_OK = 8'h00;
	localparam logic [7:0] QE_VERIFY_FAIL = 8'h01;
	localparam logic [7:0] QE_OTHER = 8'h02;
	localparam logic [7:0] QE_BLANK = 8'hF0;
	localparam logic [7:0] QE_NOT_BLANK = 8'h0F;

	// Executive software version, major and minor nibble
	localparam logic [3:0] VERSION_MAJOR = 4'h1;
	localparam logic [3:0] VERSION_MINOR = 4'h0;

	// Response length and row erase constants
	localparam logic [15:0] HDR_LEN = 16'h0002;
	localparam logic [23:0] ROW_STEP = 24'h000020;
	localparam logic [23:0] ROW_ALIGN_MASK = 24'h00001F;
	localparam logic [7:0] MAX_ROWS = 8'h80;
	localparam logic [7:0] PROTECT_PAGE = 8'hF8;
	localparam logic [7:0] ERASE_FILL_BYTE = 8'hFF;

	// Response buffer shape
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 4;

	// First command word
	typedef struct packed {
		logic [3:0] opcode;
		logic [3:0] rsvd;
		logic [7:0] length;
	} spe_cmd_hdr_t;

	// Second word of the row erase command
	typedef struct packed {
		logic [7:0] num_rows;
		logic [7:0] addr_high;
	} spe_erase_w1_t;

	// First response word
	typedef struct packed {
		logic [3:0] status;
		logic [3:0] opcode;
		logic [7:0] query_error_field;
	} spe_rsp_hdr_t;

endpackage

// ===== rtl/spe_fifo.sv
module spe_fifo #(
	parameter int W = 16,
	parameter int D = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic empty
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_q [D]; // Word storage
	logic [AW:0] wr_q; // Write pointer with wrap bit
	logic [AW:0] rd_q; // Read pointer with wrap bit
	logic full; // All slots hold words
	logic push; // Word accepted
	logic pop; // Word delivered

	assign empty = (wr_q == rd_q);
	assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_q[rd_q[AW-1:0]];
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;

	// Pointer update
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	// Storage write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < D; i++) begin
				mem_q[i] <= '0;
			end
		end else if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

endmodule

// ===== verif/spe_top_assertions.sv
module spe_top_assertions (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic PROG_DATA_PIN_O,
	input wire logic PROG_DATA_PIN_OE,
	input wire logic [15:0] VISIBLE_RESULT_REG,
	input wire logic CPU_IDLE,
	input wire logic INSTR_VALID,
	input wire logic CMD_READY,
	input wire logic OP_START,
	input wire logic ERASE_ROW_REQ,
	input wire logic [23:0] ERASE_ROW_ADDR,
	input wire logic [7:0] ERASE_FILL,
	input wire logic [15:0] RSP_WORD,
	input wire logic RSP_VALID,
	input wire logic RSP_READY
);
	// One clock domain, one reset
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	// Data pin turns round to an output
	sequence s_shift_on;
		$rose(PROG_DATA_PIN_OE);
	endsequence
	// First result bit shown, processor still held
	sequence s_first_bit;
		CPU_IDLE && PROG_DATA_PIN_O == VISIBLE_RESULT_REG[0];
	endsequence
	a_shift_first_bit: assert property (s_shift_on |-> s_first_bit)
		else $error("first shifted bit or idle wrong");
	a_shift_hold: assert property (s_shift_on |=> PROG_DATA_PIN_OE [*8])
		else $error("data pin released too early");
	a_drive_idle: assert property (PROG_DATA_PIN_OE |-> CPU_IDLE)
		else $error("pin driven while processor runs");
	a_fill_value: assert property (ERASE_FILL == 8'hFF)
		else $error("erase fill not all ones");
	a_row_aligned: assert property (ERASE_ROW_REQ |-> ERASE_ROW_ADDR[4:0] == 5'h00)
		else $error("row address not aligned");
	a_row_unprot: assert property (ERASE_ROW_REQ |-> ERASE_ROW_ADDR[23:16] < 8'hF8)
		else $error("row erase reached protected page");
	a_cmd_hold_off: assert property (RSP_VALID |-> !CMD_READY)
		else $error("command taken while response pending");
	a_busy_no_cmd: assert property (ERASE_ROW_REQ || OP_START |-> !CMD_READY)
		else $error("command taken while operation runs");
	a_rsp_stands: assert property (RSP_VALID && !RSP_READY |=>
		RSP_VALID && $stable(RSP_WORD))
		else $error("response word changed while stalled");
	a_instr_pulse: assert property (INSTR_VALID |=> !INSTR_VALID)
		else $error("instruction strobe longer than one cycle");
endmodule

bind spe_top spe_top_assertions i_spe_top_assertions (
	.CLK, .ARST_N, .PROG_DATA_PIN_O, .PROG_DATA_PIN_OE, .VISIBLE_RESULT_REG,
	.CPU_IDLE, .INSTR_VALID, .CMD_READY, .OP_START, .ERASE_ROW_REQ,
	.ERASE_ROW_ADDR, .ERASE_FILL, .RSP_WORD, .RSP_VALID, .RSP_READY
);

// ===== verif/spe_prog_model.sv
module spe_prog_model (
	output logic clk_pin,
	output logic dat_pin,
	input wire logic line_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Link clock stands low between frames
	initial begin
		clk_pin = 1'b0;
		dat_pin = 1'b0;
	end
	// One bit set up in the low phase, taken on the rise
	task automatic put_bit(input logic b);
		dat_pin = b;
		#100 clk_pin = 1'b1;
		#100 clk_pin = 1'b0;
	endtask
	// Control code, then payload, least significant bit first
	task automatic send(input logic [3:0] code, input logic [23:0] data,
		input int n);
		for (int i = 0; i < 4; i++) put_bit(code[i]);
		for (int i = 0; i < n; i++) put_bit(data[i]);
	endtask
	// Shift-out code, eight idle rises, then sixteen result bits
	task automatic read_out(output logic [15:0] v);
		send(4'h1, 24'h000000, 0);
		// Released line shows the inverse of the last bit
		dat_pin = ~dat_pin;
		for (int i = 0; i < 8; i++) begin
			#100 clk_pin = 1'b1;
			#100 clk_pin = 1'b0;
		end
		// Sample just before each rise
		for (int i = 0; i < 16; i++) begin
			#95 v[i] = line_in;
			#5 clk_pin = 1'b1;
			#100 clk_pin = 1'b0;
		end
	endtask
endmodule

// ===== verif/spe_top_test.sv
module spe_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, arst_n, pclk, pdat, pin_i, pin_o, pin_oe, cpu_idle;
	logic instr_valid, cmd_valid, cmd_ready, op_start, op_done, op_vf;
	logic op_fail, blank, erase_req, erase_done, rd_valid, rd_ready;
	logic rsp_valid, rsp_ready, want_vf, want_fail, arg_valid;
	logic [15:0] vis, cmd_word, rd_word, rsp_word, arg_word, arg_last;
	logic [23:0] instr, erase_addr;
	logic [7:0] fill;
	logic [3:0] op_code;
	logic [2:0] er_pipe, op_pipe;
	logic [15:0] rsp_q[$];
	logic [23:0] addr_q[$];
	int err_count, num_checks, n_instr;
	// Resolved data pin level
	assign pin_i = pin_oe ? pin_o : pdat;
	spe_top i_spe_top (.CLK(clk), .ARST_N(arst_n), .PROG_CLOCK_PIN(pclk),
		.PROG_DATA_PIN_I(pin_i), .PROG_DATA_PIN_O(pin_o),
		.PROG_DATA_PIN_OE(pin_oe), .VISIBLE_RESULT_REG(vis),
		.CPU_IDLE(cpu_idle), .INSTR_WORD(instr), .INSTR_VALID(instr_valid),
		.CMD_WORD(cmd_word), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.ARG_WORD(arg_word), .ARG_VALID(arg_valid), .OP_START(op_start),
		.OP_CODE(op_code),
		.OP_DONE(op_done), .OP_VERIFY_FAIL(op_vf), .OP_FAIL(op_fail),
		.MEM_BLANK(blank), .ERASE_ROW_REQ(erase_req),
		.ERASE_ROW_ADDR(erase_addr), .ERASE_FILL(fill),
		.ERASE_ROW_DONE(erase_done), .RD_WORD(rd_word), .RD_VALID(rd_valid),
		.RD_READY(rd_ready), .RSP_WORD(rsp_word), .RSP_VALID(rsp_valid),
		.RSP_READY(rsp_ready));
	spe_prog_model i_spe_prog_model (.clk_pin(pclk), .dat_pin(pdat),
		.line_in(pin_i));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Far-side memory and operation engine, answering later
	always @(posedge clk) begin
		er_pipe <= {er_pipe[1:0], erase_req};
		op_pipe <= {op_pipe[1:0], op_start};
		erase_done <= er_pipe[2];
		op_done <= op_pipe[2];
		op_vf <= op_pipe[2] & want_vf;
		op_fail <= op_pipe[2] & want_fail;
		if (erase_req) addr_q.push_back(erase_addr);
		if (arg_valid) arg_last <= arg_word;
		if (instr_valid) n_instr <= n_instr + 1;
		if (rsp_valid && rsp_ready) rsp_q.push_back(rsp_word);
		if (rd_valid && rd_ready) rd_word <= rd_word + 16'h0001;
	end
	// Verdict and end of run
	task automatic test_done;
		if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bound used up
	task automatic hang(input string what);
		chk(what, 24'h000001, 24'h000000);
		test_done();
	endtask
	// Hand command words over, each held until taken
	task automatic send_cmd(input logic [15:0] w[$]);
		foreach (w[i]) begin
			cmd_word <= w[i];
			cmd_valid <= 1'b1;
			for (int k = 0; k <= 400; k++) begin
				@(negedge clk);
				if (k == 400) hang("cmd ready");
				if (cmd_ready === 1'b1) break;
			end
			@(posedge clk);
		end
		cmd_valid <= 1'b0;
	endtask
	// Wait for a whole response and compare it word by word
	task automatic expect_rsp(input logic [15:0] w[$]);
		for (int k = 0; rsp_q.size() < w.size(); k++) begin
			if (k == 3000) hang("response");
			@(posedge clk);
		end
		foreach (w[i]) chk("rsp", {8'h00, w[i]}, {8'h00, rsp_q.pop_front()});
		repeat (3) @(posedge clk);
		chk("rsp extra", 24'h000000, 24'(rsp_q.size()));
	endtask
	// Row erase, good or refused
	task automatic t_erase(input logic [7:0] rows, input logic [23:0] base,
		input logic [15:0] h);
		addr_q = {};
		send_cmd('{16'h8003, {rows, base[23:16]}, base[15:0]});
		expect_rsp('{h, 16'h0002});
		chk("rows", (h == 16'h1800) ? 24'(rows) : 24'h000000,
			24'(addr_q.size()));
		chk("arg", {8'h00, base[15:0]}, {8'h00, arg_last});
		foreach (addr_q[i]) chk("row", base + 24'(i) * 24'h20, addr_q[i]);
		chk("fill", 24'h0000FF, {16'h0000, fill});
	endtask
	// Operation with chosen outcome
	task automatic t_op(input logic [3:0] op, input logic vf, input logic f,
		input logic [15:0] h);
		want_vf <= vf;
		want_fail <= f;
		send_cmd('{{op, 12'h001}});
		expect_rsp('{h, 16'h0002});
		chk("op code", {20'h00000, op}, {20'h00000, op_code});
	endtask
	// Read with the response link stalled until the buffer refuses
	task automatic t_read(input logic [3:0] op, input logic [7:0] n,
		input logic [15:0] len);
		logic [15:0] w[$];
		w = '{{spe_pkg::RSP_PASS, op, 8'h00}, len};
		for (int i = 0; i < len - 2; i++) w.push_back(16'hC000 + 16'(i));
		rd_word <= 16'hC000;
		rsp_ready <= 1'b0;
		send_cmd('{{op, 12'h004}, {8'h00, n}, 16'h0000, 16'h0000});
		repeat (40) @(posedge clk);
		chk("rd held", 24'h000000, {23'h000000, rd_ready});
		rsp_ready <= 1'b1;
		expect_rsp(w);
	endtask
	// Queries and reserved codes
	task automatic t_query;
		blank <= 1'b1;
		send_cmd('{16'hA003, 16'h0000, 16'h0000});
		expect_rsp('{16'h1AF0, 16'h0002});
		blank <= 1'b0;
		send_cmd('{16'hA003, 16'h0000, 16'h0000});
		expect_rsp('{16'h1A0F, 16'h0002});
		send_cmd('{16'hB001});
		expect_rsp('{{spe_pkg::RSP_PASS, 4'hB, spe_pkg::VERSION_MAJOR,
			spe_pkg::VERSION_MINOR}, 16'h0002});
		send_cmd('{16'h3001});
		expect_rsp('{16'h3300, 16'h0002});
		send_cmd('{16'hC001});
		expect_rsp('{16'h3C00, 16'h0002});
	endtask
	// Serial payload and result shift-out
	task automatic t_serial;
		logic [15:0] v;
		logic [23:0] s[$];
		int n0;
		i_spe_prog_model.send(4'h0, 24'h040100, 24);
		repeat (8) @(posedge clk);
		chk("instr", 24'h040100, instr);
		vis <= 16'hA5C3;
		@(posedge clk);
		i_spe_prog_model.read_out(v);
		chk("shift", 24'h00A5C3, {8'h00, v});
		repeat (8) @(posedge clk);
		chk("pin free", 24'h000000, {23'h000000, pin_oe});
		chk("idle held", 24'h000001, {23'h000000, cpu_idle});
		// Serial bulk erase preamble, code 0000 for every step
		s = '{24'h040100, 24'h040100, 24'h000000,
			24'h200F80, 24'h880190, 24'h200067,
			24'hEB0300, 24'h000000, 24'hBB1B86,
			24'h200558, 24'h200AA9, 24'h883B38, 24'h883B39,
			24'hA8E761, 24'h000000, 24'hA9E761,
			24'hBB1B86, 24'h200558, 24'h200AA9, 24'h883B38,
			24'h883B39, 24'hA8E761, 24'h000000, 24'hA9E761,
			24'h2407FA, 24'h883B0A};
		n0 = n_instr;
		foreach (s[i]) begin
			i_spe_prog_model.send(4'h0, s[i], 24);
			repeat (8) @(posedge clk);
			chk("seq", s[i], instr);
		end
		chk("strobes", 24'(s.size()), 24'(n_instr - n0));
		chk("idle off", 24'h000000, {23'h000000, cpu_idle});
	endtask
	// Main sequence
	initial begin
		arst_n = 1'b0;
		{vis, cmd_word, rd_word} = '0;
		{cmd_valid, op_done, op_vf, op_fail, blank, erase_done} = '0;
		{er_pipe, op_pipe, want_vf, want_fail} = '0;
		rd_valid = 1'b1;
		rsp_ready = 1'b1;
		err_count = 0;
		num_checks = 0;
		n_instr = 0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_erase(8'h02, 24'h010040, 16'h1800);
		t_erase(8'h80, 24'h000000, 16'h1800);
		t_erase(8'h81, 24'h000000, 16'h2802);
		t_erase(8'h01, 24'h010044, 16'h2802);
		t_erase(8'h01, 24'hF80000, 16'h2802);
		t_query();
		t_op(4'h6, 1'b1, 1'b0, 16'h2601);
		t_op(4'h5, 1'b1, 1'b0, 16'h2501);
		t_op(4'h7, 1'b1, 1'b0, 16'h2702);
		t_op(4'h7, 1'b0, 1'b1, 16'h2702);
		t_op(4'h4, 1'b0, 1'b0, 16'h1400);
		t_op(4'h9, 1'b1, 1'b0, 16'h2902);
		t_op(4'h0, 1'b0, 1'b0, 16'h1000);
		t_read(4'h1, 8'h05, 16'h0007);
		t_read(4'h2, 8'h03, 16'h0008);
		t_read(4'h2, 8'h02, 16'h0005);
		t_serial();
		test_done();
	end
endmodule
